// file: hw/eeprom_slave_consts.svh
// Constants for the two-wire serial memory slave interface
`ifndef EEPROM_SLAVE_CONSTS_SVH
`define EEPROM_SLAVE_CONSTS_SVH

`define CLK_PERIOD_NS 10
`define PROG_CYCLE_STD_MS 10
`define PROG_CYCLE_LV_MS 15
`define PROG_CYCLES_STD ((`PROG_CYCLE_STD_MS * 1000000) / `CLK_PERIOD_NS)
`define PROG_CYCLES_LV ((`PROG_CYCLE_LV_MS * 1000000) / `CLK_PERIOD_NS)
`define DEV_TYPE_MSB 7
`define DEV_TYPE_LSB 4
`define SEL_MSB 3
`define SEL_LSB 1
`define DIR_BIT 0
`define DIR_READ 1'b1
`define FIFO_DEPTH 8
`define BYTE_BITS 8

`endif

// file: hw/eeprom_slave_pkg.sv
// Types for the two-wire serial memory slave interface
package eeprom_slave_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_TXACK,
        ST_IGNORE
    } slave_state_t;
    typedef enum logic [1:0] {
        BY_SLAVE,
        BY_ADDR,
        BY_DATA
    } byte_kind_t;
endpackage

// file: hw/byte_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_sys_clk,          // System clock
    input wire logic i_rst,              // Sync reset, active high
    input wire logic i_in_valid,         // Write side valid
    output logic o_in_ready,             // Write side ready (not full)
    input wire logic [WIDTH-1:0] i_in_data, // Write data
    output logic o_out_valid,            // Read side valid (not empty)
    input wire logic i_out_ready,        // Read side ready
    output logic [WIDTH-1:0] o_out_data  // Read data, registered
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic [WIDTH-1:0] out_data_r;
    logic out_valid_r;
    logic push;
    logic pop;
    logic load;

    // The output register counts toward the depth, so DEPTH words in all
    assign o_in_ready = (count_r + (AW+1)'(out_valid_r)) !=
                        (AW+1)'(DEPTH);
    assign push = i_in_valid && o_in_ready;
    // Output register holds the head; refill it when drained or empty
    assign load = (count_r != '0) && (!out_valid_r || i_out_ready);
    assign pop = load;
    assign o_out_valid = out_valid_r;
    assign o_out_data = out_data_r;

    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= i_in_data;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
            end
            if (pop) begin
                rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
            end
            count_r <= (AW+1)'(count_r + (push ? 1 : 0) - (pop ? 1 : 0));
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            out_valid_r <= 1'b0;
            out_data_r <= '0;
        end else if (load) begin
            out_valid_r <= 1'b1;
            out_data_r <= mem_r[rd_ptr_r];
        end else if (i_out_ready) begin
            out_valid_r <= 1'b0;
        end
    end
endmodule

// file: hw/eeprom_slave.sv
// Two-wire serial memory slave: framing, addressing, ack and busy period
`timescale 1ns/1ps
`include "eeprom_slave_consts.svh"

// What this block does
// [RULE1] Master opens each transaction with START before any byte.
// [RULE2] Addressed receiver acknowledges every received byte. The device leaves a data byte unacked when its write buffer is full.
// [RULE3] Missing acknowledge from the receiver ends the transfer.
// [RULE4] Device acks in writes; master acks bytes the device sends in reads.
// [RULE5] Master closes each transaction with STOP after the last byte.
// [RULE6] Slave address byte, then after ack the array address byte.
// [RULE7] Slave address: 4-bit type, 3-bit select, direction bit last.
// [RULE8] All three select bits must equal the strap pins to be selected.
// [RULE9] Program cycle starts at STOP ending a write; 10 or 15 ms.
// [RULE10] While programming, interface disabled and own address not acked.
// [RULE11] While programming the data line stays released.
// [RULE12] Direction bit 1 means read, 0 means write.
// [RULE13] Receiver drives data low on the 9th clock, then releases.
// [RULE14] Array address byte picks one of 256 bytes in the page block.
// [RULE15] Data changes only while clock low; changes while high are START/STOP.
// [RULE16] Mismatched address: no ack, line released, ignore until START.
module eeprom_slave
    import eeprom_slave_pkg::*;
#(
    parameter int PROG_CYCLES = `PROG_CYCLES_STD,
    parameter logic [3:0] DEVICE_TYPE = 4'h5 // Arbitrary value
) (
    input wire logic i_sys_clk,            // System clock, 100 MHz
    input wire logic i_rst,                // Sync reset, active high
    input wire logic i_scl,                // Serial clock pin
    input wire logic i_sda,                // Serial data pin, input side
    output logic o_sda,                    // Serial data pin, output value
    output logic o_sda_oe,                 // Serial data drive enable
    input wire logic i_select_strap_bit0,  // Select strap pin 0
    input wire logic i_select_strap_bit1,  // Select strap pin 1
    input wire logic i_select_strap_bit2,  // Select strap pin 2
    output logic o_wr_valid,               // Written byte available
    input wire logic i_wr_ready,           // Array accepts written byte
    output logic [7:0] o_wr_addr,          // Array address of written byte
    output logic [7:0] o_wr_data,          // Written byte
    output logic o_rd_req,                 // Pulse: read byte at o_rd_addr
    output logic [7:0] o_rd_addr,          // Array address for read
    input wire logic [7:0] i_rd_data,      // Read byte, sampled at the edge ending the o_rd_req pulse
    output logic o_busy                    // Program cycle in progress
);
    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic scl_d_r;
    logic sda_d_r;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    slave_state_t state_r;
    byte_kind_t kind_r;
    logic [7:0] shift_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] addr_r;
    logic read_r;
    logic wrote_r;
    logic ack_drive_r;
    logic tx_drive_r;
    logic rd_pending_r;
    logic [31:0] busy_cnt_r;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [15:0] fifo_out;
    logic [2:0] strap;

    function automatic logic addr_match(input logic [7:0] b,
                                        input logic [2:0] s);
        addr_match = (b[`DEV_TYPE_MSB:`DEV_TYPE_LSB] == DEVICE_TYPE) &&
                     (b[`SEL_MSB:`SEL_LSB] == s); // see [RULE7] [RULE8]
    endfunction

    assign strap = {i_select_strap_bit2, i_select_strap_bit1,
                    i_select_strap_bit0};

    // Pins come from another domain; two stages before any use
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_sync_r <= {scl_sync_r[0], i_scl};
            sda_sync_r <= {sda_sync_r[0], i_sda};
            scl_d_r <= scl_sync_r[1];
            sda_d_r <= sda_sync_r[1];
        end
    end

    assign scl_rise = scl_sync_r[1] && !scl_d_r;
    assign scl_fall = !scl_sync_r[1] && scl_d_r;
    // Data edges while clock high are framing, never data
    assign start_det = scl_sync_r[1] && scl_d_r && sda_d_r &&
                       !sda_sync_r[1]; // see [RULE15] [RULE1]
    assign stop_det = scl_sync_r[1] && scl_d_r && !sda_d_r &&
                      sda_sync_r[1]; // see [RULE15] [RULE5]

    assign o_busy = (busy_cnt_r != '0);

    // Program timer; started by STOP closing a write with data
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            busy_cnt_r <= '0;
        end else if (stop_det && wrote_r && !o_busy) begin
            busy_cnt_r <= 32'(PROG_CYCLES); // see [RULE9]
        end else if (o_busy) begin
            busy_cnt_r <= busy_cnt_r - 32'h1;
        end
    end

    // Protocol engine
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_r <= ST_IDLE;
            kind_r <= BY_SLAVE;
            shift_r <= '0;
            bit_cnt_r <= '0;
            addr_r <= '0;
            read_r <= 1'b0;
            wrote_r <= 1'b0;
            ack_drive_r <= 1'b0;
            tx_drive_r <= 1'b0;
            rd_pending_r <= 1'b0;
        end else if (o_busy) begin
            // Interface disabled: line released, nothing decoded
            state_r <= ST_IDLE; // see [RULE10] [RULE11]
            ack_drive_r <= 1'b0;
            tx_drive_r <= 1'b0;
            wrote_r <= 1'b0;
            rd_pending_r <= 1'b0;
        end else if (start_det) begin
            state_r <= ST_RX; // see [RULE1]
            kind_r <= BY_SLAVE;
            bit_cnt_r <= '0;
            ack_drive_r <= 1'b0;
            tx_drive_r <= 1'b0;
            wrote_r <= 1'b0;
        end else if (stop_det) begin
            state_r <= ST_IDLE; // see [RULE5]
            ack_drive_r <= 1'b0;
            tx_drive_r <= 1'b0;
        end else begin
            rd_pending_r <= 1'b0;
            if (rd_pending_r) begin
                shift_r <= i_rd_data;
            end
            unique case (state_r)
                ST_IDLE, ST_IGNORE: begin
                    ack_drive_r <= 1'b0; // see [RULE16]
                end
                ST_RX: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], sda_sync_r[1]};
                        bit_cnt_r <= 4'(bit_cnt_r + 1'b1);
                    end else if (scl_fall && bit_cnt_r == 4'h8) begin
                        bit_cnt_r <= '0;
                        state_r <= ST_ACK;
                        unique case (kind_r)
                            BY_SLAVE: begin
                                if (addr_match(shift_r, strap)) begin
                                    ack_drive_r <= 1'b1; // see [RULE13]
                                    read_r <= shift_r[`DIR_BIT] ==
                                              `DIR_READ; // see [RULE12]
                                end else begin
                                    state_r <= ST_IGNORE; // see [RULE16]
                                end
                            end
                            BY_ADDR: begin
                                addr_r <= shift_r; // see [RULE6] [RULE14]
                                ack_drive_r <= 1'b1;
                            end
                            BY_DATA: begin
                                // Full buffer: withhold ack to end transfer
                                ack_drive_r <= fifo_in_ready; // see [RULE2]
                                if (fifo_in_ready) begin
                                    addr_r <= addr_r + 8'h1;
                                    wrote_r <= 1'b1;
                                end
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        ack_drive_r <= 1'b0; // see [RULE13]
                        if (!ack_drive_r) begin
                            state_r <= ST_IGNORE; // see [RULE3]
                        end else if (kind_r == BY_SLAVE && read_r) begin
                            state_r <= ST_TX; // see [RULE4]
                            rd_pending_r <= 1'b1;
                            tx_drive_r <= 1'b1;
                        end else begin
                            state_r <= ST_RX;
                            kind_r <= (kind_r == BY_SLAVE) ? BY_ADDR :
                                      BY_DATA;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_r == 4'h7) begin
                            bit_cnt_r <= '0;
                            tx_drive_r <= 1'b0; // see [RULE13]
                            state_r <= ST_TXACK;
                            addr_r <= addr_r + 8'h1;
                        end else begin
                            shift_r <= {shift_r[6:0], 1'b0};
                            bit_cnt_r <= 4'(bit_cnt_r + 1'b1);
                        end
                    end
                end
                ST_TXACK: begin
                    if (scl_rise) begin
                        if (sda_sync_r[1]) begin
                            state_r <= ST_IGNORE; // see [RULE3] [RULE4]
                        end else begin
                            bit_cnt_r <= 4'hf;
                        end
                    end else if (scl_fall && bit_cnt_r == 4'hf) begin
                        bit_cnt_r <= '0;
                        state_r <= ST_TX;
                        rd_pending_r <= 1'b1;
                        tx_drive_r <= 1'b1;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Open drain: only ever pull low
    assign o_sda = 1'b0;
    // Mask the stale top bit for the one cycle before read data lands
    assign o_sda_oe = !o_busy && (ack_drive_r ||
                      (tx_drive_r && !rd_pending_r &&
                       !shift_r[7])); // see [RULE11] [RULE15]

    assign o_rd_req = rd_pending_r;
    assign o_rd_addr = addr_r;
    assign fifo_in_valid = state_r == ST_RX && kind_r == BY_DATA &&
                           scl_fall && bit_cnt_r == 4'h8 &&
                           !start_det && !stop_det && !o_busy;

    byte_fifo #(
        .WIDTH(16),
        .DEPTH(`FIFO_DEPTH)
    ) u_wr_fifo (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_in_valid(fifo_in_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data({addr_r, shift_r}),
        .o_out_valid(o_wr_valid),
        .i_out_ready(i_wr_ready),
        .o_out_data(fifo_out)
    );

    assign o_wr_addr = fifo_out[15:8];
    assign o_wr_data = fifo_out[7:0];
endmodule

// file: tb/eeprom_slave_properties.sv
// Concurrent checks on the serial memory slave ports
`timescale 1ns/1ps
module eeprom_slave_properties #(
    parameter int PROG_CYCLES = 200
) (
    input wire logic i_sys_clk, // System clock
    input wire logic i_rst, // Sync reset
    input wire logic i_scl, // Serial clock pin
    input wire logic i_sda, // Serial data pin
    input wire logic o_sda, // Data output value
    input wire logic o_sda_oe, // Data drive enable
    input wire logic o_wr_valid, // Written byte valid
    input wire logic i_wr_ready, // Array ready
    input wire logic [7:0] o_wr_addr, // Write address
    input wire logic [7:0] o_wr_data, // Write data
    input wire logic o_rd_req, // Read request pulse
    input wire logic o_busy // Program cycle running
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    int busy_len;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || !o_busy) begin
            busy_len <= 0;
        end else begin
            busy_len <= busy_len + 1;
        end
    end
    busy_quiet_a: assert property (
        o_busy |-> !o_sda_oe)
        else $error("data line driven in program cycle");
    busy_bound_a: assert property (
        $fell(o_busy) |-> busy_len == PROG_CYCLES)
        else $error("program cycle length wrong");
    busy_hold_a: assert property (
        $rose(o_busy) |-> o_busy [*8])
        else $error("program cycle not held");
    busy_idle_a: assert property (
        $rose(o_busy) |-> i_scl && i_sda)
        else $error("program cycle began off a stop");
    open_drain_a: assert property (
        o_sda_oe |-> o_sda == 1'b0)
        else $error("data line driven high");
    drive_low_a: assert property (
        $rose(o_sda_oe) |-> !i_scl)
        else $error("drive began with clock high");
    release_low_a: assert property (
        $fell(o_sda_oe) |-> !i_scl)
        else $error("release with clock high");
    ack_hold_a: assert property (
        $rose(o_sda_oe) |-> o_sda_oe [*8])
        else $error("low drive too short");
    rd_pulse_a: assert property (
        o_rd_req |=> !o_rd_req)
        else $error("read request longer than a cycle");
    wr_hold_a: assert property (
        o_wr_valid && !i_wr_ready |=>
        o_wr_valid && $stable({o_wr_addr, o_wr_data}))
        else $error("written byte dropped while stalled");
endmodule
bind eeprom_slave eeprom_slave_properties #(.PROG_CYCLES(PROG_CYCLES)) chk (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_wr_valid(o_wr_valid),
    .i_wr_ready(i_wr_ready), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data),
    .o_rd_req(o_rd_req), .o_busy(o_busy));

// file: tb/bus_master.sv
// Two-wire bus master model, clock stands high between frames
`timescale 1ns/1ps
module bus_master (
    output logic o_scl, // Serial clock
    output logic o_sda_low, // High while pulling data low
    input wire logic i_sda // Resolved data line
);
    localparam realtime Q = 31.25;
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // Also serves as repeated start, entered with the clock low
    task automatic start();
        o_sda_low = 1'b0;
        #Q o_scl = 1'b1;
        #Q o_sda_low = 1'b1;
        #Q o_scl = 1'b0;
        #Q;
    endtask
    task automatic clk_bit(input logic b, output logic s);
        o_sda_low = !b;
        #Q o_scl = 1'b1;
        #Q s = i_sda;
        #Q o_scl = 1'b0;
        #Q;
    endtask
    // Send tx (all ones to listen), then give or take the ninth bit
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                        input logic ack_in, output logic ack_out);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(tx[i], s);
            rx[i] = s;
        end
        clk_bit(ack_in, ack_out);
    endtask
    task automatic stop();
        o_sda_low = 1'b1;
        #Q o_scl = 1'b1;
        #Q o_sda_low = 1'b0;
        #(4 * Q);
    endtask
endmodule

// file: tb/eeprom_slave_tb_top.sv
// Self-checking bench for the serial memory slave
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
    error_cnt++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module eeprom_slave_tb_top;
    localparam int PROG = 200;
    localparam logic [3:0] DTYPE = 4'h6; // Arbitrary type code
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic scl, m_low, sda, o_sda, oe, wr_valid, rd_req, busy;
    logic wr_ready = 1'b0;
    logic hold = 1'b0;
    logic [2:0] strap = 3'h0;
    logic [7:0] wr_addr, wr_data, rd_addr;
    logic [7:0] rd_data = 8'h00;
    logic [7:0] mem [256];
    logic [15:0] wq [$];
    logic [15:0] note;
    int error_cnt = 0;
    int check_count = 0;
    assign sda = !(m_low || oe); // Pull-up holds the free line high
    always #5 clk = ~clk;
    bus_master m (.o_scl(scl), .o_sda_low(m_low), .i_sda(sda));
    eeprom_slave #(.PROG_CYCLES(PROG), .DEVICE_TYPE(DTYPE)) uut (
        .i_sys_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda),
        .o_sda(o_sda), .o_sda_oe(oe), .i_select_strap_bit0(strap[0]),
        .i_select_strap_bit1(strap[1]), .i_select_strap_bit2(strap[2]),
        .o_wr_valid(wr_valid), .i_wr_ready(wr_ready), .o_wr_addr(wr_addr),
        .o_wr_data(wr_data), .o_rd_req(rd_req), .o_rd_addr(rd_addr),
        .i_rd_data(rd_data), .o_busy(busy));
    always @(negedge clk) begin
        wr_ready <= !hold && ($urandom % 3 != 0);
        rd_data <= mem[rd_addr];
    end
    always @(posedge clk) begin
        if (!rst && wr_valid === 1'b1 && wr_ready) begin
            note = (wq.size() > 0) ? wq.pop_front() : 16'hxxxx;
            `CHK({wr_addr, wr_data}, note)
            mem[wr_addr] = wr_data;
        end
    end
    task automatic report_and_stop();
        if (error_cnt == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Offset frames from the clock edges so no pin moves on one
    task automatic go();
        @(negedge clk);
        #1 m.start();
    endtask
    task automatic send(input logic [7:0] b, input logic ack);
        logic [7:0] r;
        logic a;
        m.xfer(b, r, 1'b1, a);
        `CHK(a, !ack)
    endtask
    task automatic wait_prog();
        int n;
        n = 0;
        while (busy !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        `CHK(busy, 1'b1)
        go();
        send({DTYPE, strap, 1'b0}, 1'b0);
        m.stop();
        n = 0;
        while (busy !== 1'b0 && n < 2 * PROG) begin
            @(negedge clk);
            n++;
        end
        `CHK(busy, 1'b0)
        if (busy !== 1'b0) report_and_stop();
    endtask
    task automatic burst(input logic [7:0] a, input int n, input int ok);
        logic [7:0] d;
        go();
        send({DTYPE, strap, 1'b0}, 1'b1);
        send(a, 1'b1);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            if (i < ok) wq.push_back({a + 8'(i), d});
            send(d, 1'(i < ok));
        end
        m.stop();
        hold = 1'b0;
        wait_prog();
    endtask
    task automatic rd_seq(input logic [7:0] a, input int n);
        logic [7:0] r;
        logic k;
        go();
        send({DTYPE, strap, 1'b0}, 1'b1);
        send(a, 1'b1);
        m.start();
        send({DTYPE, strap, 1'b1}, 1'b1);
        for (int i = 0; i < n; i++) begin
            m.xfer(8'hff, r, 1'(i == n - 1), k);
            `CHK(r, mem[a + 8'(i)])
        end
        m.stop();
        `CHK(sda, 1'b1)
        `CHK(busy, 1'b0)
    endtask
    initial begin
        void'($urandom(36257));
        strap = 3'($urandom);
        foreach (mem[i]) mem[i] = 8'($urandom);
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        // Each select bit wrong in turn, then the type field wrong
        for (int i = 0; i < 4; i++) begin
            go();
            send({(i < 3) ? DTYPE : ~DTYPE, strap ^ 3'((1 << i) & 7),
                  1'b0}, 1'b0);
            send({DTYPE, strap, 1'b0}, 1'b0);
            m.stop();
        end
        burst(8'hfe, 5, 5);
        hold = 1'b1;
        // Eight words fill the buffer; the ninth byte must go unacked
        burst(8'h40, 9, 8);
        `CHK(wr_valid, 1'b0)
        rd_seq(8'hfe, 3);
        rd_seq(8'h40, 8);
        // Every noted write must have come out of the buffer
        `CHK(wq.size(), 0)
        report_and_stop();
    end
endmodule
